// ==== include/oodt_pkg.sv ====
// Shared constants and types for the on-delay / off-delay timer pair
package oodt_pkg;

	// Timebase selection for a delay value
	typedef enum logic [1:0] {
		TB_SEC,
		TB_MIN,
		TB_HOUR
	} oodt_tb_t;

	// Clock and base tick (10 ns clock, 10 ms base tick)
	localparam int unsigned CLK_PERIOD_NS = 32'h0000_000A;
	localparam int unsigned TICK_BASE_NS = 32'h0098_9680;
	localparam int unsigned TICK_BASE_CYC = TICK_BASE_NS / CLK_PERIOD_NS;
	// 100 base ticks per second, 60 seconds per minute
	localparam int unsigned BASE_PER_SEC = 32'h0000_0064;
	localparam int unsigned SEC_PER_MIN = 32'h0000_003C;

	// Elapsed count, in units of the selected resolution
	localparam int ELAPSED_W = 14;
	localparam logic [ELAPSED_W-1:0] ELAPSED_RST = 14'h0000;
	localparam logic [ELAPSED_W-1:0] ELAPSED_ONE = 14'h0001;
	localparam logic Q_RST = 1'b0;

	// Constant delay fields hh:ll; 99:99 seconds, 99:59 minutes or hours
	localparam int CONST_W = 7;
	localparam int unsigned CONST_HI_MAX = 32'h0000_0063;
	localparam int unsigned CONST_LO_MAX_SEC = 32'h0000_0063;
	localparam int unsigned CONST_LO_MAX_MIN = 32'h0000_003B;
	localparam int unsigned SCALE_SEC = 32'h0000_0064;
	localparam int unsigned SCALE_MIN = 32'h0000_003C;

	// Referenced value limits: 99990 ms, 5999 s, 5999 min
	localparam int unsigned REF_MS_MAX = 32'h0001_8696;
	localparam int unsigned REF_MS_PER_UNIT = 32'h0000_000A;
	localparam int unsigned REF_S_MAX = 32'h0000_176F;
	localparam int unsigned REF_M_MAX = 32'h0000_176F;

	// Largest delay in resolution units per timebase
	localparam logic [ELAPSED_W-1:0] DLY_MAX_SEC = 14'h270F;
	localparam logic [ELAPSED_W-1:0] DLY_MAX_MIN = 14'h176F;

	// Bank of other blocks' actual values, chosen by block number
	localparam int NUM_REF = 8;
	localparam int REF_W = 32;
	localparam int REF_SEL_W = 3;

endpackage : oodt_pkg

// ==== verilog/oodt_tick.sv ====
// Enable divider: one-cycle tick every DIV input enables
`timescale 1ns/1ps
module oodt_tick #(
	parameter int unsigned DIV = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Input rate
	input wire logic en,
	// Output rate
	output logic tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] CNT_LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] CNT_ZERO = '0;
	localparam logic [CW-1:0] CNT_ONE = CW'(1);

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic tick_next;

	wire wrap = en && (cnt_reg == CNT_LAST);
	assign cnt_next = !en ? cnt_reg : (wrap ? CNT_ZERO : cnt_reg + CNT_ONE);
	assign tick_next = wrap;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= CNT_ZERO;
			tick <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick <= tick_next;
		end
	end

endmodule : oodt_tick

// ==== verilog/oodt_timers.sv ====
// On-delay and off-delay timer pair with selectable delay source
`timescale 1ns/1ps
module oodt_timers #(
	parameter int unsigned TICK_BASE_CYC = oodt_pkg::TICK_BASE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Actual values of other blocks, block 0 in the low word
	input wire logic [oodt_pkg::NUM_REF*oodt_pkg::REF_W-1:0] ref_values,
	// Saved state offered at power return
	input wire logic restore_valid,
	input wire logic on_restore_q,
	input wire logic [oodt_pkg::ELAPSED_W-1:0] on_restore_elapsed,
	input wire logic off_restore_q,
	input wire logic [oodt_pkg::ELAPSED_W-1:0] off_restore_elapsed,
	// On-delay timer
	input wire logic on_trg,
	input wire logic on_retentive,
	input wire logic on_src_ref,
	input wire oodt_pkg::oodt_tb_t on_tb,
	input wire logic [oodt_pkg::CONST_W-1:0] on_const_hi,
	input wire logic [oodt_pkg::CONST_W-1:0] on_const_lo,
	input wire logic [oodt_pkg::REF_SEL_W-1:0] on_ref_sel,
	output logic on_q,
	output logic [oodt_pkg::ELAPSED_W-1:0] on_elapsed_count,
	// Off-delay timer
	input wire logic off_trg,
	input wire logic off_clr,
	input wire logic off_retentive,
	input wire logic off_src_ref,
	input wire oodt_pkg::oodt_tb_t off_tb,
	input wire logic [oodt_pkg::CONST_W-1:0] off_const_hi,
	input wire logic [oodt_pkg::CONST_W-1:0] off_const_lo,
	input wire logic [oodt_pkg::REF_SEL_W-1:0] off_ref_sel,
	output logic off_q,
	output logic [oodt_pkg::ELAPSED_W-1:0] off_elapsed_count
);
	localparam int EW = oodt_pkg::ELAPSED_W;
	localparam int RW = oodt_pkg::REF_W;

	// Delay in resolution units, clamped to the timebase range
	function automatic logic [EW-1:0] calc_delay(
		input logic src_ref,
		input oodt_pkg::oodt_tb_t tb,
		input logic [oodt_pkg::CONST_W-1:0] hi,
		input logic [oodt_pkg::CONST_W-1:0] lo,
		input logic signed [RW-1:0] rv
	);
		logic [31:0] h;
		logic [31:0] l;
		logic [31:0] lmax;
		logic [31:0] v;
		h = 32'(hi);
		l = 32'(lo);
		lmax = (tb == oodt_pkg::TB_SEC) ? oodt_pkg::CONST_LO_MAX_SEC :
			oodt_pkg::CONST_LO_MAX_MIN;
		v = '0;
		if (!src_ref) begin
			h = (h > oodt_pkg::CONST_HI_MAX) ? oodt_pkg::CONST_HI_MAX : h;
			l = (l > lmax) ? lmax : l;
			if (tb == oodt_pkg::TB_SEC) begin
				v = h * oodt_pkg::SCALE_SEC + l;
			end else begin
				v = h * oodt_pkg::SCALE_MIN + l;
			end
		end else if (rv < 32'sh0000_0000) begin
			v = '0;
		end else begin
			v = 32'(rv);
			case (tb)
				oodt_pkg::TB_SEC: begin
					if (v > oodt_pkg::REF_MS_MAX) begin
						v = oodt_pkg::REF_MS_MAX;
					end
					v = v / oodt_pkg::REF_MS_PER_UNIT;
				end
				oodt_pkg::TB_MIN: begin
					v = (v > oodt_pkg::REF_S_MAX) ? oodt_pkg::REF_S_MAX : v;
				end
				default: begin
					v = (v > oodt_pkg::REF_M_MAX) ? oodt_pkg::REF_M_MAX : v;
				end
			endcase
		end
		return EW'(v);
	endfunction : calc_delay

	// Timebase ticks: 10 ms, 1 s, 1 min
	logic tick_base;
	logic tick_sec;
	logic tick_min;

	oodt_tick #(.DIV(TICK_BASE_CYC)) u_tick_base (
		.clk(clk),
		.rst(rst),
		.en(1'b1),
		.tick(tick_base)
	);

	oodt_tick #(.DIV(oodt_pkg::BASE_PER_SEC)) u_tick_sec (
		.clk(clk),
		.rst(rst),
		.en(tick_base),
		.tick(tick_sec)
	);

	oodt_tick #(.DIV(oodt_pkg::SEC_PER_MIN)) u_tick_min (
		.clk(clk),
		.rst(rst),
		.en(tick_sec),
		.tick(tick_min)
	);

	// State
	logic start_reg;
	logic on_trg_prev_reg;
	logic off_trg_prev_reg;
	logic [EW-1:0] on_elapsed_next;
	logic [EW-1:0] off_elapsed_next;
	logic on_q_next;
	logic off_q_next;

	// Delay source selection
	wire logic signed [RW-1:0] on_ref_val = ref_values[on_ref_sel*RW +: RW];
	wire logic signed [RW-1:0] off_ref_val = ref_values[off_ref_sel*RW +: RW];
	wire logic [EW-1:0] on_delay = calc_delay(on_src_ref, on_tb,
		on_const_hi, on_const_lo, on_ref_val);
	wire logic [EW-1:0] off_delay = calc_delay(off_src_ref, off_tb,
		off_const_hi, off_const_lo, off_ref_val);

	// Resolution tick per timer
	wire logic on_tick = (on_tb == oodt_pkg::TB_SEC) ? tick_base :
		(on_tb == oodt_pkg::TB_MIN) ? tick_sec : tick_min;
	wire logic off_tick = (off_tb == oodt_pkg::TB_SEC) ? tick_base :
		(off_tb == oodt_pkg::TB_MIN) ? tick_sec : tick_min;

	// Edges and expiry, compared every cycle
	wire logic on_rise = on_trg && !on_trg_prev_reg;
	wire logic off_fall = !off_trg && off_trg_prev_reg;
	wire logic on_done = on_elapsed_count >= on_delay;
	wire logic off_done = off_elapsed_count >= off_delay;
	wire logic on_restore = restore_valid && on_retentive;
	wire logic off_restore = restore_valid && off_retentive;

	// On-delay next state
	always_comb begin
		on_q_next = on_q;
		on_elapsed_next = on_elapsed_count;
		if (start_reg) begin
			// First cycle after power return
			on_q_next = on_restore ? on_restore_q : oodt_pkg::Q_RST;
			on_elapsed_next = on_restore ? on_restore_elapsed :
				oodt_pkg::ELAPSED_RST;
		end else if (!on_trg) begin
			on_q_next = 1'b0;
			on_elapsed_next = oodt_pkg::ELAPSED_RST;
		end else if (on_rise) begin
			on_q_next = 1'b0;
			on_elapsed_next = oodt_pkg::ELAPSED_RST;
		end else if (on_done) begin
			// Count saturates so the output holds while the trigger stays high
			on_q_next = 1'b1;
		end else if (on_tick) begin
			on_elapsed_next = on_elapsed_count + oodt_pkg::ELAPSED_ONE;
		end
	end

	// Off-delay next state; clear outranks the trigger
	always_comb begin
		off_q_next = off_q;
		off_elapsed_next = off_elapsed_count;
		if (start_reg) begin
			off_q_next = off_restore ? off_restore_q : oodt_pkg::Q_RST;
			off_elapsed_next = off_restore ? off_restore_elapsed :
				oodt_pkg::ELAPSED_RST;
		end else if (off_clr) begin
			off_q_next = 1'b0;
			off_elapsed_next = oodt_pkg::ELAPSED_RST;
		end else if (off_trg) begin
			off_q_next = 1'b1;
			off_elapsed_next = oodt_pkg::ELAPSED_RST;
		end else if (off_fall) begin
			off_elapsed_next = oodt_pkg::ELAPSED_RST;
		end else if (off_q) begin
			if (off_done) begin
				off_q_next = 1'b0;
			end else if (off_tick) begin
				off_elapsed_next = off_elapsed_count + oodt_pkg::ELAPSED_ONE;
			end
		end
	end

	// Restore happens in a clocked cycle after release, never in reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_reg <= 1'b1;
			on_trg_prev_reg <= 1'b0;
			off_trg_prev_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			on_trg_prev_reg <= on_trg;
			off_trg_prev_reg <= off_trg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			on_q <= oodt_pkg::Q_RST;
			on_elapsed_count <= oodt_pkg::ELAPSED_RST;
			off_q <= oodt_pkg::Q_RST;
			off_elapsed_count <= oodt_pkg::ELAPSED_RST;
		end else begin
			on_q <= on_q_next;
			on_elapsed_count <= on_elapsed_next;
			off_q <= off_q_next;
			off_elapsed_count <= off_elapsed_next;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_ON_RISE: assert property (
		(!start_reg && on_rise) |=> (on_elapsed_count == 14'h0000) && !on_q
	) else $error("on-delay count not restarted on rising trigger");

	AST_ON_FIRE: assert property (
		(!start_reg && on_trg && !on_rise && on_done) |=> on_q
	) else $error("on-delay output not set at expiry");

	AST_ON_ABORT: assert property (
		(!start_reg && on_trg_prev_reg && !on_trg && !on_done)
		|=> (on_elapsed_count == 14'h0000) && !on_q
	) else $error("on-delay not cleared when trigger dropped early");

	AST_ON_LOW: assert property (
		(!start_reg && !on_trg) |=> !on_q
	) else $error("on-delay output high with trigger low");

	AST_RESTORE: assert property (
		// Sampled rst keeps the release edge itself out of the start check
		(!rst && start_reg && on_restore) |=> (on_q == $past(on_restore_q))
		&& (on_elapsed_count == $past(on_restore_elapsed))
	) else $error("retentive on-delay state not restored");

	AST_NO_RESTORE: assert property (
		(!rst && start_reg && !off_restore)
		|=> !off_q && (off_elapsed_count == 14'h0000)
	) else $error("non-retentive off-delay not at defaults");

	AST_CONST_SEC: assert property (
		(!on_src_ref && on_tb == oodt_pkg::TB_SEC && on_const_hi == 7'h01
		&& on_const_lo == 7'h02) |-> on_delay == 14'h0066
	) else $error("constant seconds delay miscomputed");

	AST_CLAMP: assert property (
		(on_tb == oodt_pkg::TB_SEC) ? (on_delay <= oodt_pkg::DLY_MAX_SEC)
		: (on_delay <= oodt_pkg::DLY_MAX_MIN)
	) else $error("on-delay value outside its timebase range");

	AST_OFF_SET: assert property (
		(!start_reg && off_trg && !off_clr) |=> off_q
		&& (off_elapsed_count == 14'h0000)
	) else $error("off-delay output not set with trigger high");

	AST_OFF_FALL: assert property (
		(!start_reg && off_fall && !off_clr && off_q)
		|=> off_q && (off_elapsed_count == 14'h0000)
	) else $error("off-delay not restarted on falling trigger");

	AST_OFF_EXPIRE: assert property (
		(!start_reg && !off_trg && !off_trg_prev_reg && !off_clr && off_done)
		|=> !off_q
	) else $error("off-delay output not cleared at expiry");

	AST_OFF_CLR: assert property (
		(!start_reg && off_clr) |=> !off_q && (off_elapsed_count == 14'h0000)
	) else $error("off-delay clear ignored");

	AST_TICK_STEP: assert property (
		(!start_reg && on_trg && !on_rise && !on_done && on_tick)
		|=> on_elapsed_count == $past(on_elapsed_count) + 14'h0001
	) else $error("on-delay count missed a tick");

	AST_TICK_HOLD: assert property (
		(!start_reg && !off_trg && !off_fall && !off_clr && !off_tick)
		|=> $stable(off_elapsed_count)
	) else $error("off-delay count moved without a tick");

endmodule : oodt_timers

// ==== dv/oodt_ref_model.sv ====
// Model of the neighbouring blocks whose actual values feed the delays
`timescale 1ns/1ps
module oodt_ref_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Value update from the bench
	input wire logic set_en,
	input wire logic [2:0] set_idx,
	input wire logic [31:0] set_val,
	// Actual values, block 0 in the low word
	output logic [255:0] ref_values
);
	// A neighbour updates its actual value on the cycle clock, never between
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_values <= '0;
		end else if (set_en) begin
			ref_values[set_idx * 32 +: 32] <= set_val;
		end
	end
endmodule : oodt_ref_model

// ==== dv/tb_top.sv ====
// Self-checking bench for the on-delay / off-delay timer pair
`timescale 1ns/1ps
module tb_top;
	// Short base tick keeps second ticks at 400 cycles
	localparam int P = 4;
	logic clk = 1'b0, rst = 1'b1, set_en = 1'b0, restore_valid = 1'b0;
	logic on_restore_q = 1'b0, off_restore_q = 1'b0, on_q, off_q;
	logic on_trg = 1'b0, on_retentive = 1'b0, on_src_ref = 1'b0;
	logic off_trg = 1'b0, off_clr = 1'b0, off_retentive = 1'b0;
	logic off_src_ref = 1'b0;
	logic [2:0] set_idx = 3'h0, on_ref_sel = 3'h0, off_ref_sel = 3'h0;
	logic [6:0] on_const_hi = 7'h00, on_const_lo = 7'h03;
	logic [6:0] off_const_hi = 7'h00, off_const_lo = 7'h00;
	logic [13:0] on_restore_elapsed = 14'h0000;
	logic [13:0] off_restore_elapsed = 14'h0000;
	logic [13:0] on_elapsed_count, off_elapsed_count;
	logic [31:0] set_val = 32'h0000_0000;
	logic [255:0] ref_values;
	oodt_pkg::oodt_tb_t on_tb = oodt_pkg::TB_SEC, off_tb = oodt_pkg::TB_SEC;
	int error_cnt = 0, n_compared = 0, n;

	oodt_ref_model oodt_ref_model_i (.clk, .rst, .set_en, .set_idx, .set_val,
		.ref_values);
	oodt_timers #(.TICK_BASE_CYC(P)) oodt_timers_i (.clk, .rst, .ref_values,
		.restore_valid, .on_restore_q, .on_restore_elapsed, .off_restore_q,
		.off_restore_elapsed, .on_trg, .on_retentive, .on_src_ref, .on_tb,
		.on_const_hi, .on_const_lo, .on_ref_sel, .on_q, .on_elapsed_count,
		.off_trg, .off_clr, .off_retentive, .off_src_ref, .off_tb,
		.off_const_hi, .off_const_lo, .off_ref_sel, .off_q,
		.off_elapsed_count);

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [13:0] exp,
		input logic [13:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Outputs are read at the falling edge, well clear of their update
	task automatic mid(input int k);
		repeat (k) @(negedge clk);
	endtask : mid

	task automatic edge_n(input int k);
		repeat (k) @(posedge clk);
	endtask : edge_n

	task automatic set_ref(input logic [2:0] idx, input logic [31:0] v);
		@(posedge clk);
		set_idx <= idx;
		set_val <= v;
		set_en <= 1'b1;
		@(posedge clk);
		set_en <= 1'b0;
	endtask : set_ref

	// Bounded wait for a timer output; a limit reached shows as a mismatch
	task automatic wait_q(input logic off, input logic v, input int lim,
		output int k);
		k = 0;
		while (k < lim && (off ? off_q : on_q) !== v) begin
			@(negedge clk);
			k++;
		end
		chk("q level", 14'(v), 14'(off ? off_q : on_q));
	endtask : wait_q

	task automatic on_run(input logic [13:0] d, input int lim);
		@(posedge clk);
		on_trg <= 1'b1;
		mid(1);
		wait_q(1'b0, 1'b1, lim, n);
		chk("on_elapsed_count", d, on_elapsed_count);
		@(posedge clk);
		on_trg <= 1'b0;
		mid(2);
	endtask : on_run

	task automatic tally_and_finish();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#(10 * 60000);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		edge_n(2);
		rst <= 1'b0;
		mid(3);
		chk("on_q", 14'h0000, 14'(on_q));
		chk("off_q", 14'h0000, 14'(off_q));
		@(posedge clk);
		on_trg <= 1'b1;
		mid(2);
		chk("on_elapsed_count", 14'h0000, on_elapsed_count);
		wait_q(1'b0, 1'b1, 40, n);
		chk("on_elapsed_count", 14'h0003, on_elapsed_count);
		chk("on_span", 14'h0001, 14'(n >= 2 * P && n <= 3 * P + 3));
		mid(5);
		chk("on_q", 14'h0001, 14'(on_q));
		chk("on_elapsed_count", 14'h0003, on_elapsed_count);
		@(posedge clk);
		on_trg <= 1'b0;
		mid(2);
		chk("on_q", 14'h0000, 14'(on_q));
		// Drop part way: at most two ticks of three have passed
		@(posedge clk);
		on_trg <= 1'b1;
		edge_n(2 * P);
		on_trg <= 1'b0;
		mid(2);
		chk("on_q", 14'h0000, 14'(on_q));
		chk("on_elapsed_count", 14'h0000, on_elapsed_count);
		set_ref(3'h5, 32'hFFFF_FFF9);
		on_src_ref <= 1'b1;
		on_ref_sel <= 3'h5;
		on_tb <= oodt_pkg::TB_HOUR;
		@(posedge clk);
		on_trg <= 1'b1;
		mid(3);
		chk("on_q", 14'h0001, 14'(on_q));
		@(posedge clk);
		on_trg <= 1'b0;
		set_ref(3'h5, 32'h0000_0019);
		on_tb <= oodt_pkg::TB_SEC;
		on_run(14'h0002, 40);
		set_ref(3'h3, 32'h0000_0001);
		on_ref_sel <= 3'h3;
		on_tb <= oodt_pkg::TB_MIN;
		on_run(14'h0001, 1000);
		set_ref(3'h3, 32'h0001_D4C0);
		on_tb <= oodt_pkg::TB_SEC;
		on_run(14'h270F, 41000);
		chk("on_elapsed_count", 14'h0000, on_elapsed_count);
		set_ref(3'h2, 32'h0000_0032);
		off_src_ref <= 1'b1;
		off_ref_sel <= 3'h2;
		@(posedge clk);
		off_trg <= 1'b1;
		mid(2);
		chk("off_q", 14'h0001, 14'(off_q));
		@(posedge clk);
		off_trg <= 1'b0;
		mid(2);
		chk("off_q", 14'h0001, 14'(off_q));
		chk("off_elapsed_count", 14'h0000, off_elapsed_count);
		edge_n(2 * P);
		off_trg <= 1'b1;
		@(posedge clk);
		off_trg <= 1'b0;
		mid(2);
		chk("off_q", 14'h0001, 14'(off_q));
		chk("off_elapsed_count", 14'h0000, off_elapsed_count);
		wait_q(1'b1, 1'b0, 40, n);
		chk("off_elapsed_count", 14'h0005, off_elapsed_count);
		chk("off_span", 14'h0001, 14'(n >= 4 * P));
		@(posedge clk);
		off_trg <= 1'b1;
		@(posedge clk);
		off_trg <= 1'b0;
		edge_n(P);
		off_clr <= 1'b1;
		off_trg <= 1'b1;
		mid(2);
		chk("off_q", 14'h0000, 14'(off_q));
		chk("off_elapsed_count", 14'h0000, off_elapsed_count);
		// Power loss with saved state offered to both timers
		@(posedge clk);
		off_clr <= 1'b0;
		off_trg <= 1'b0;
		on_retentive <= 1'b1;
		restore_valid <= 1'b1;
		on_restore_q <= 1'b1;
		on_restore_elapsed <= 14'h0005;
		off_restore_q <= 1'b1;
		off_restore_elapsed <= 14'h0004;
		on_src_ref <= 1'b0;
		on_const_lo <= 7'h05;
		on_trg <= 1'b1;
		rst <= 1'b1;
		edge_n(2);
		rst <= 1'b0;
		mid(3);
		chk("on_q", 14'h0001, 14'(on_q));
		chk("on_elapsed_count", 14'h0005, on_elapsed_count);
		chk("off_q", 14'h0000, 14'(off_q));
		chk("off_elapsed_count", 14'h0000, off_elapsed_count);
		// Constant 01:02 in seconds is 102 units of 10 ms
		@(posedge clk);
		on_trg <= 1'b0;
		on_const_hi <= 7'h01;
		on_const_lo <= 7'h02;
		on_run(14'h0066, 500);
		tally_and_finish();
	end
endmodule : tb_top
